// file: rwm_params.svh
// Timing counts and reset values for the wire mode data port
`ifndef RWM_PARAMS_SVH
`define RWM_PARAMS_SVH
`define RWM_CLK_MHZ        100
`define RWM_TDCK_MIN_NS    1600
`define RWM_TDCK_MAX_US    10000
`define RWM_HALF_MIN_CYC   ((`RWM_TDCK_MIN_NS * `RWM_CLK_MHZ / 1000 + 1) / 2)
`define RWM_HALF_MAX_CYC   (`RWM_TDCK_MAX_US * `RWM_CLK_MHZ / 2)
`define RWM_HALF_W         20
`define RWM_HALF_DEFAULT   20'h00050
`define RWM_RST_STRETCH    4'hF
`endif

// file: rwm_pkg.sv
// Types shared by the wire mode data port modules
package rwm_pkg;
    typedef enum logic [1:0] {RWM_SYNC_WIRE, RWM_ASYNC_WIRE, RWM_FRAME} rwm_mode_t;
    typedef enum logic {RWM_IDLE, RWM_ACTIVE} rwm_async_st_t;
endpackage : rwm_pkg

// file: rwm_clk_if.sv
// Bit clock strobes passed from the generator to the port logic, and resync passed back to the generator
interface rwm_clk_if;
    logic rise;
    logic fall;
    logic level;
    logic resync;
    modport gen  (output rise, output fall, output level, input resync);
    modport user (input rise, input fall, input level, output resync);
endinterface : rwm_clk_if

// file: rwm_bitclk_gen.sv
// Bit clock divider with resynchronisation restart
`include "rwm_params.svh"
module rwm_bitclk_gen
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // Half period in clk cycles
    input  wire logic [`RWM_HALF_W-1:0]   halfPeriod,
    // Strobes
    rwm_clk_if.gen                        bc
);
    logic [`RWM_HALF_W-1:0] count;
    logic                   level;
    wire  [`RWM_HALF_W-1:0] lo  = `RWM_HALF_W'(`RWM_HALF_MIN_CYC);
    wire  [`RWM_HALF_W-1:0] hi  = `RWM_HALF_W'(`RWM_HALF_MAX_CYC);
    // Clamp keeps the period inside the legal span even if misprogrammed
    wire  [`RWM_HALF_W-1:0] lim = (halfPeriod < lo) ? lo : ((halfPeriod > hi) ? hi : halfPeriod);
    wire                    wrap = (count >= lim - `RWM_HALF_W'(1));

    // Divider; resync restarts a low phase so the next rise lands mid start bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
            level <= 1'b0;
        end
        else if (bc.resync)
        begin
            count <= '0;
            level <= 1'b0;
        end
        else if (wrap)
        begin
            count <= '0;
            level <= ~level;
        end
        else
            count <= count + `RWM_HALF_W'(1);
    end

    assign bc.rise  = wrap && !level && !bc.resync;
    assign bc.fall  = wrap && level && !bc.resync;
    assign bc.level = level;
endmodule : rwm_bitclk_gen

// file: rwm_wire_port.sv
// Wire mode data port: bit clock, data direction, async resync, reset control
`include "rwm_params.svh"
module rwm_wire_port
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   resetPinN,
    // Configuration from the SPI register file
    input  wire rwm_pkg::rwm_mode_t     mode,
    input  wire logic [`RWM_HALF_W-1:0] bitHalfPeriod,
    input  wire logic                   powerModeTx,
    input  wire logic                   useTxEnablePin,
    input  wire logic                   softResetBit,
    // Modem side
    output logic                        txBit,
    output logic                        txBitValid,
    input  wire logic                   rxBit,
    output logic                        packetCtrlEnable,
    output logic                        deviceReset,
    // Pins
    input  wire logic                   irqOrTxEnablePin,
    input  wire logic                   dataIn,
    output logic                        dataOut,
    output logic                        dataOe,
    output logic                        bitClockOut,
    output logic                        bitClockOe,
    // General purpose use of the pins in frame mode
    input  wire logic                   gpioDataOut,
    input  wire logic                   gpioDataOe,
    input  wire logic                   gpioClkOut,
    input  wire logic                   gpioClkOe,
    output logic                        gpioDataIn
);
    import rwm_pkg::*;

    rwm_clk_if bc ();

    // Synchroniser stages for pins from outside the clock domain
    logic [1:0]    txEnSync;
    logic [1:0]    dataSync;
    logic [1:0]    rstPinSync;
    // Edge and toggle detection history
    logic          dataPrev;
    logic          softPrev;
    // Reset stretch counter and receive bit holding register
    logic [3:0]    rstStretch;
    logic          rxHold;
    // Start bit search state
    rwm_async_st_t asyncSt;
    rwm_async_st_t next_asyncSt;

    // Transmit sample strike: wire mode, transmit direction, bit clock rising
    function automatic logic rwm_tx_strike(input logic wm, input logic dir, input logic rise);
        rwm_tx_strike = wm && dir && rise;
    endfunction : rwm_tx_strike

    // Direction pin; idles low so transmit waits for two clean samples
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            txEnSync <= 2'h0;
        end
        else
        begin
            txEnSync <= {txEnSync[0], irqOrTxEnablePin};
        end
    end

    // Data pin; idles high like a released serial line, so no false start bit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dataSync <= 2'h3;
        end
        else
        begin
            dataSync <= {dataSync[0], dataIn};
        end
    end

    // Reset pin; reads low until synchronised so reset holds after power-up
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstPinSync <= 2'h0;
        end
        else
        begin
            rstPinSync <= {rstPinSync[0], resetPinN};
        end
    end

    // Mode and direction decoding
    wire dataS     = dataSync[1];
    wire wireMode  = (mode != RWM_FRAME);
    wire asyncMode = (mode == RWM_ASYNC_WIRE);
    wire txDir     = useTxEnablePin ? txEnSync[1] : powerModeTx;
    // Start bit: synchronised data falling while idle in async transmit
    wire startEdge = asyncMode && txDir && dataPrev && !dataS && (asyncSt == RWM_IDLE);
    wire txStrike  = rwm_tx_strike(wireMode, txDir, bc.rise);
    assign bc.resync = startEdge;

    // Bit clock generator; resync lands three cycles after the pin falls
    rwm_bitclk_gen u_gen
    (
        .clk        (clk),
        .nrst       (nrst),
        .halfPeriod (bitHalfPeriod),
        .bc         (bc)
    );

    // Start bit search: idle until a falling edge, then active until two high samples in a row
    always_comb
    begin
        next_asyncSt = asyncSt;
        case (asyncSt)
            RWM_IDLE:
            begin
                // Falling data while idle marks a start bit
                if (startEdge)
                    next_asyncSt = RWM_ACTIVE;
            end
            RWM_ACTIVE:
            begin
                // Two high samples in a row mean stop bit then idle line
                if (bc.rise && dataS && txBit)
                    next_asyncSt = RWM_IDLE;
            end
            default:
            begin
                next_asyncSt = RWM_IDLE;
            end
        endcase
    end

    // Edge history and search state; search is parked outside async mode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dataPrev <= 1'b1;
            asyncSt  <= RWM_IDLE;
        end
        else
        begin
            dataPrev <= dataS;
            asyncSt  <= asyncMode ? next_asyncSt : RWM_IDLE;
        end
    end

    // Transmit sampling on bit clock rise; mid-bit, far from host changes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            txBit      <= 1'b1;
            txBitValid <= 1'b0;
        end
        else
        begin
            txBitValid <= txStrike;
            if (txStrike)
            begin
                txBit <= dataS;
            end
        end
    end

    // Receive update on bit clock fall so the host samples on the rise
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rxHold <= 1'b1;
        end
        else if (bc.fall)
        begin
            rxHold <= rxBit;
        end
    end

    // Reset: soft bit toggle or pin low; stretched so it spans several cycles
    wire softToggle = softResetBit != softPrev;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            softPrev <= 1'b0;
        end
        else
        begin
            softPrev <= softResetBit;
        end
    end

    // Stretch counter; any toggle of the soft bit counts, either direction
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstStretch <= `RWM_RST_STRETCH;
        end
        else if (softToggle || !rstPinSync[1])
        begin
            rstStretch <= `RWM_RST_STRETCH;
        end
        else if (rstStretch != 4'h0)
        begin
            rstStretch <= rstStretch - 4'h1;
        end
    end
    assign deviceReset = (rstStretch != 4'h0);

    // Pin muxing: wire mode owns the pins, frame mode hands them to GPIO
    assign packetCtrlEnable = !wireMode;
    assign dataOe      = wireMode ? !txDir : gpioDataOe;
    assign dataOut     = wireMode ? rxHold : gpioDataOut;
    assign bitClockOut = wireMode ? bc.level : gpioClkOut;
    assign bitClockOe  = wireMode ? 1'b1 : gpioClkOe;
    assign gpioDataIn  = dataS;
endmodule : rwm_wire_port

// file: rwm_wire_port_props.sv
// Property checker for the wire mode data port
module rwm_wire_port_props
    import rwm_pkg::*;
(
    // Watched ports
    input wire logic clk, nrst, resetPinN, powerModeTx, useTxEnablePin, softResetBit, irqOrTxEnablePin,
    input wire rwm_pkg::rwm_mode_t mode,
    input wire logic [19:0] bitHalfPeriod,
    input wire logic txBitValid, packetCtrlEnable, deviceReset, dataOe, bitClockOut, gpioDataOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [19:0] cyc;
    logic        seen;
    // Cycles since the last bit clock rise; first rise only arms
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst) cyc <= '0;
        else cyc <= $rose(bitClockOut) ? 20'h00001 : cyc + 20'h00001;
        if (!nrst) seen <= 1'b0;
        else seen <= seen | $rose(bitClockOut);
    end
    property p_period; $rose(bitClockOut) && seen && mode == RWM_SYNC_WIRE |-> cyc == {bitHalfPeriod[18:0], 1'b0}; endproperty
    a_period: assert property (p_period) else $error("bit clock period wrong");
    property p_edge; txBitValid |-> $rose(bitClockOut); endproperty
    a_edge: assert property (p_edge) else $error("sample not on rise");
    property p_bypass; mode != RWM_FRAME |-> !packetCtrlEnable; endproperty
    a_bypass: assert property (p_bypass) else $error("controller on in wire mode");
    property p_frame; mode == RWM_FRAME |-> packetCtrlEnable; endproperty
    a_frame: assert property (p_frame) else $error("controller off in frame mode");
    property p_hiz; (mode != RWM_FRAME && !useTxEnablePin && powerModeTx) [*4] |-> !dataOe; endproperty
    a_hiz: assert property (p_hiz) else $error("data driven in transmit");
    property p_pin; (mode != RWM_FRAME && useTxEnablePin && !irqOrTxEnablePin) [*4] |-> dataOe; endproperty
    a_pin: assert property (p_pin) else $error("data not driven in receive");
    property p_gpio; (mode == RWM_FRAME && $stable(gpioDataOe)) [*4] |-> dataOe == gpioDataOe; endproperty
    a_gpio: assert property (p_gpio) else $error("data pin not general purpose");
    property p_noval; (mode == RWM_FRAME) [*3] |-> !txBitValid; endproperty
    a_noval: assert property (p_noval) else $error("sampling in frame mode");
    property p_pinlow; !resetPinN [*4] |-> deviceReset; endproperty
    a_pinlow: assert property (p_pinlow) else $error("reset pin ignored");
    property p_pinrel; $rose(resetPinN) |-> deviceReset [*8] ##[6:14] !deviceReset; endproperty
    a_pinrel: assert property (p_pinrel) else $error("reset release wrong");
    property p_soft; $changed(softResetBit) |-> ##2 deviceReset [*8]; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
endmodule : rwm_wire_port_props

// file: rwm_host_model.sv
// Host port model driving transmit bits on the data pin
module rwm_host_model
(
    input  wire logic en,
    input  wire logic newBit,
    input  wire logic bitClockOut,
    output logic      hostBit
);
    timeunit 1ns;
    timeprecision 1ns;
    initial hostBit = 1'b1;
    // Change on the fall so the rise sees a settled bit; released line flips
    always @(negedge bitClockOut)
        hostBit <= en ? newBit : ~hostBit;
endmodule : rwm_host_model

// file: test_rwm_wire_port.sv
// Self-checking bench for the wire mode data port
module test_rwm_wire_port;
    timeunit 1ns;
    timeprecision 1ns;
    import rwm_pkg::*;
    logic clk = 0, nrst = 0, resetPinN = 1, powerModeTx = 1, useTxEnablePin = 0, softResetBit = 0, rxBit = 0;
    logic irqOrTxEnablePin = 1, gpioDataOe = 0, txMode = 0, rxMode = 0, asyncDrv = 0, asyncBit = 1, newBit = 0, prev;
    rwm_mode_t mode = RWM_SYNC_WIRE;
    logic [19:0] bitHalfPeriod = 20'h00050;
    logic [31:0] seed = 32'h7C10311A;
    logic gpioDataOut = 0, gpioClkOut = 0, gpioClkOe = 0;
    wire txBit, txBitValid, packetCtrlEnable, deviceReset, dataOut, dataOe, bitClockOut, gpioDataIn, hostBit;
    wire bitClockOe;
    wire dataIn = dataOe ? dataOut : asyncDrv ? asyncBit : hostBit;
    int num_errors = 0, checked = 0, d;
    logic txQ[$], rxQ[$];
    rwm_wire_port u_dut
    (
        .clk              (clk),
        .nrst             (nrst),
        .resetPinN        (resetPinN),
        .mode             (mode),
        .bitHalfPeriod    (bitHalfPeriod),
        .powerModeTx      (powerModeTx),
        .useTxEnablePin   (useTxEnablePin),
        .softResetBit     (softResetBit),
        .txBit            (txBit),
        .txBitValid       (txBitValid),
        .rxBit            (rxBit),
        .packetCtrlEnable (packetCtrlEnable),
        .deviceReset      (deviceReset),
        .irqOrTxEnablePin (irqOrTxEnablePin),
        .dataIn           (dataIn),
        .dataOut          (dataOut),
        .dataOe           (dataOe),
        .bitClockOut      (bitClockOut),
        .bitClockOe       (bitClockOe),
        .gpioDataOut      (gpioDataOut),
        .gpioDataOe       (gpioDataOe),
        .gpioClkOut       (gpioClkOut),
        .gpioClkOe        (gpioClkOe),
        .gpioDataIn       (gpioDataIn)
    );
    rwm_host_model u_host (.en(txMode), .newBit, .bitClockOut, .hostBit);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // Bounded wait for the reset stretch to end
    task automatic settle();
        for (d = 0; d < 100 && deviceReset !== 1'b0; d++) @(posedge clk);
        check("deviceReset", deviceReset, 1'b0);
    endtask : settle
    always #5 clk = ~clk;
    always @(posedge clk) seed <= lfsr(seed);
    // Note bits handed over at each fall, then move to fresh random ones
    always @(negedge bitClockOut)
    begin
        if (txMode) txQ.push_back(newBit);
        if (rxMode) rxQ.push_back(rxBit);
        newBit <= seed[3];
        rxBit <= seed[7];
    end
    // Compare results as they appear at the ports
    always @(posedge clk) if (txBitValid && txQ.size() > 0) check("txBit", txBit, txQ.pop_front());
    always @(posedge bitClockOut) if (rxQ.size() > 0) check("dataOut", dataOut, rxQ.pop_front());
    initial
    begin
        #200us;
        num_errors++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        settle();
        check("packetCtrlEnable", packetCtrlEnable, 1'b0);
        check("bitClockOe", bitClockOe, 1'b1);
        @(posedge bitClockOut) txMode <= 1'b1;
        repeat (1600) @(posedge clk);
        @(posedge bitClockOut) txMode <= 1'b0;
        useTxEnablePin <= 1'b1;
        irqOrTxEnablePin <= 1'b0;
        repeat (10) @(posedge clk);
        check("dataOe", dataOe, 1'b1);
        @(posedge bitClockOut) rxMode <= 1'b1;
        repeat (1600) @(posedge clk);
        @(posedge bitClockOut) rxMode <= 1'b0;
        @(posedge bitClockOut) irqOrTxEnablePin <= 1'b1;
        repeat (10) @(posedge clk);
        check("dataOe", dataOe, 1'b0);
        // Start bit at a random phase must restart the bit timing
        asyncDrv <= 1'b1;
        mode <= RWM_ASYNC_WIRE;
        repeat (400 + seed[5:0]) @(posedge clk);
        asyncBit <= 1'b0;
        prev = 1'b1;
        for (d = 0; d < 300 && !(d > 3 && prev === 1'b0 && bitClockOut === 1'b1); d++)
        begin
            prev = bitClockOut;
            @(posedge clk);
        end
        check("resync", d inside {[82:86]}, 1'b1);
        asyncBit <= 1'b1;
        softResetBit <= 1'b1;
        repeat (3) @(posedge clk);
        check("deviceReset", deviceReset, 1'b1);
        settle();
        resetPinN <= 1'b0;
        repeat (10) @(posedge clk);
        check("deviceReset", deviceReset, 1'b1);
        resetPinN <= 1'b1;
        settle();
        mode <= RWM_FRAME;
        repeat (40)
        begin
            @(posedge clk);
            gpioDataOe  <= seed[9];
            gpioDataOut <= seed[13];
            gpioClkOut  <= seed[11];
            gpioClkOe   <= seed[12];
        end
        repeat (8) @(posedge clk);
        check("packetCtrlEnable", packetCtrlEnable, 1'b1);
        check("dataOe", dataOe, gpioDataOe);
        check("bitClockOut", bitClockOut, gpioClkOut);
        check("bitClockOe", bitClockOe, gpioClkOe);
        check("gpioDataIn", gpioDataIn, dataIn);
        check("txQ", txQ.size() == 0, 1'b1);
        check("rxQ", rxQ.size() == 0, 1'b1);
        finish_test();
    end
endmodule : test_rwm_wire_port
bind rwm_wire_port rwm_wire_port_props u_props
(
    .clk              (clk),
    .nrst             (nrst),
    .resetPinN        (resetPinN),
    .powerModeTx      (powerModeTx),
    .useTxEnablePin   (useTxEnablePin),
    .softResetBit     (softResetBit),
    .irqOrTxEnablePin (irqOrTxEnablePin),
    .mode             (mode),
    .bitHalfPeriod    (bitHalfPeriod),
    .txBitValid       (txBitValid),
    .packetCtrlEnable (packetCtrlEnable),
    .deviceReset      (deviceReset),
    .dataOe           (dataOe),
    .bitClockOut      (bitClockOut),
    .gpioDataOe       (gpioDataOe)
);
